// ### core/fault_reason_classifier.sv
// Summary of operation
// - never report reason code zero
// - root or half not present gives 1h
// - context entry not present gives 2h
// - badly programmed context entry gives 3h
// - address above width limit gives 4h
// - missing write permission gives 5h
// - missing read permission gives 6h
// - zero-length read cap suppresses read fault when the page allows write
// - second-stage entry fetch error gives 7h
// - root entry fetch error gives 8h
// - context entry fetch error gives 9h
// - reserved bits in present root give Ah
// - reserved bits in present context give Bh
// - reserved bits in live second-stage give Ch
`timescale 1ns/1ps
`default_nettype none

module fault_reason_classifier (
  // clock, reset, enable
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // translation result from the walker, one-cycle strobe
  input wire logic chk_valid_i,
  input wire logic [fault_reason_pkg::REQ_ID_W-1:0] chk_req_id_i,
  input wire logic [fault_reason_pkg::ADDR_W-1:0] chk_addr_i,
  input wire logic chk_is_write_i,
  input wire logic chk_is_read_i,
  input wire logic chk_zero_len_i,
  input wire logic chk_extended_i,
  input wire logic chk_root_fetch_err_i,
  input wire logic chk_root_present_i,
  input wire logic [1:0] chk_half_present_flags_i,
  input wire logic chk_root_rsvd_i,
  input wire logic chk_ctx_fetch_err_i,
  input wire logic chk_ctx_present_i,
  input wire logic chk_ctx_rsvd_i,
  input wire logic chk_ctx_bad_prog_i,
  input wire logic [fault_reason_pkg::WIDTH_W-1:0] chk_context_width_setting_i,
  input wire logic chk_ss_fetch_err_i,
  input wire logic chk_ss_rsvd_i,
  input wire logic chk_ss_live_i,
  input wire logic chk_page_read_ok_i,
  input wire logic chk_page_write_ok_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [fault_reason_pkg::APB_AW-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // fault report to recording logic
  output logic flt_valid_o,
  output logic [fault_reason_pkg::REASON_W-1:0] flt_reason_o,
  output logic [fault_reason_pkg::REQ_ID_W-1:0] flt_req_id_o,
  output logic [fault_reason_pkg::ADDR_W-1:0] flt_addr_o,
  // interrupt
  output logic irq_o
);
  import fault_reason_pkg::*;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic flt_valid;
    logic [REASON_W-1:0] flt_reason;
    logic [REQ_ID_W-1:0] flt_req_id;
    logic [ADDR_W-1:0] flt_addr;
    logic irq;
    logic zlr_cap;
    logic [WIDTH_W-1:0] max_guest_width;
    logic [STAT_W-1:0] status;
    logic [STAT_W-1:0] mask;
    logic [COUNT_W-1:0] count;
  } state_t;

  state_t state_r;
  state_t state_nxt;
  logic [REASON_W-1:0] reason;
  logic [WIDTH_W-1:0] eff_width;
  logic addr_over;
  logic [ADDR_W-1:0] width_mask;
  logic [STAT_W-1:0] set_bits;
  logic [STAT_W-1:0] status_next;
  logic wr_acc;
  logic rd_acc;

  // ----------------------------------------------------------------------
  // width check
  // ----------------------------------------------------------------------
  // smaller of guest width cap and context width; widths of 64 or more
  // cannot overflow a 64-bit address
  always_comb begin
    eff_width = (state_r.max_guest_width < chk_context_width_setting_i) ?
                state_r.max_guest_width : chk_context_width_setting_i;
    if (eff_width >= WIDTH_W'(ADDR_W)) begin
      width_mask = '1;
    end else begin
      width_mask = (ADDR_W'(1) << eff_width) - ADDR_W'(1);
    end
    addr_over = |(chk_addr_i & ~width_mask);
  end

  // ----------------------------------------------------------------------
  // reason priority, in walk order: root, context, width, paging, access
  // ----------------------------------------------------------------------
  always_comb begin
    reason = REASON_NONE;
    if (chk_root_fetch_err_i) begin
      reason = REASON_ROOT_FETCH_ERR;
    end else if (chk_extended_i ? (chk_half_present_flags_i == 2'b00)
                                : !chk_root_present_i) begin
      reason = REASON_ROOT_NOT_PRESENT;
    end else if (chk_root_rsvd_i) begin
      reason = REASON_ROOT_RSVD;
    end else if (chk_extended_i && !chk_half_present_flags_i[0]) begin
      // the half used for this request is flagged in bit 0
      reason = REASON_ROOT_NOT_PRESENT;
    end else if (chk_ctx_fetch_err_i) begin
      reason = REASON_CTX_FETCH_ERR;
    end else if (!chk_ctx_present_i) begin
      reason = REASON_CTX_NOT_PRESENT;
    end else if (chk_ctx_rsvd_i) begin
      reason = REASON_CTX_RSVD;
    end else if (chk_ctx_bad_prog_i) begin
      reason = REASON_CTX_BAD_PROG;
    end else if (addr_over) begin
      reason = REASON_ADDR_TOO_WIDE;
    end else if (chk_ss_fetch_err_i) begin
      reason = REASON_SS_FETCH_ERR;
    end else if (chk_ss_rsvd_i && chk_ss_live_i) begin
      reason = REASON_SS_RSVD;
    end else if (chk_is_write_i && !chk_page_write_ok_i) begin
      reason = REASON_NO_WRITE;
    end else if (chk_is_read_i && !chk_page_read_ok_i &&
                 !(state_r.zlr_cap && chk_zero_len_i &&
                   chk_page_write_ok_i)) begin
      reason = REASON_NO_READ;
    end
  end

  assign wr_acc = psel_i && penable_i && pwrite_i;
  assign rd_acc = psel_i && !penable_i && !pwrite_i;

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    set_bits = '0;
    state_nxt.flt_valid = 1'b0;
    // a code of zero is never a fault, so it is never emitted
    if (chk_valid_i && reason != REASON_NONE) begin
      state_nxt.flt_valid = 1'b1;
      state_nxt.flt_reason = reason;
      state_nxt.flt_req_id = chk_req_id_i;
      state_nxt.flt_addr = chk_addr_i;
      set_bits[STAT_FAULT_BIT] = 1'b1;
      if (state_r.status[STAT_FAULT_BIT]) begin
        set_bits[STAT_OVF_BIT] = 1'b1;
      end
      if (state_r.count != '1) begin
        state_nxt.count = state_r.count + COUNT_W'(1);
      end
    end
    // apb: answer in the access cycle, zero wait states
    state_nxt.pready = psel_i && !penable_i;
    state_nxt.pslverr = 1'b0;
    status_next = state_r.status;
    if (wr_acc) begin
      case (paddr_i)
        OFS_CTRL: begin
          state_nxt.zlr_cap = pwdata_i[CTRL_ZLR_BIT];
          state_nxt.max_guest_width = pwdata_i[CTRL_MAX_GUEST_WIDTH_LSB +: WIDTH_W];
        end
        OFS_STATUS: status_next = state_r.status & ~pwdata_i[STAT_W-1:0];
        OFS_MASK: state_nxt.mask = pwdata_i[STAT_W-1:0];
        OFS_COUNT: state_nxt.count = '0;
        default: ;
      endcase
    end
    // set beats a same-cycle write-one clear
    state_nxt.status = status_next | set_bits;
    if (rd_acc) begin
      case (paddr_i)
        OFS_CTRL: state_nxt.prdata = {16'h0000, 1'b0,
          state_r.max_guest_width, 7'h00, state_r.zlr_cap};
        OFS_STATUS: state_nxt.prdata = 32'(state_r.status);
        OFS_MASK: state_nxt.prdata = 32'(state_r.mask);
        OFS_LAST: state_nxt.prdata = {state_r.flt_req_id, 8'h00,
                                      state_r.flt_reason};
        OFS_COUNT: state_nxt.prdata = 32'(state_r.count);
        default: state_nxt.prdata = 32'h0000_0000;
      endcase
      state_nxt.pslverr = !(paddr_i == OFS_CTRL || paddr_i == OFS_STATUS ||
        paddr_i == OFS_MASK || paddr_i == OFS_LAST || paddr_i == OFS_COUNT);
    end else if (psel_i && !penable_i) begin
      state_nxt.prdata = '0;
      state_nxt.pslverr = !(paddr_i == OFS_CTRL || paddr_i == OFS_STATUS ||
        paddr_i == OFS_MASK || paddr_i == OFS_COUNT);
    end
    state_nxt.irq = |(state_nxt.status & state_nxt.mask);
  end

  // ----------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      state_r <= '0;
      state_r.max_guest_width <= MAX_GUEST_WIDTH_RESET;
    end else if (ce_i) begin
      state_r <= state_nxt;
    end
  end

  assign prdata_o = state_r.prdata;
  assign pready_o = state_r.pready;
  assign pslverr_o = state_r.pslverr;
  assign flt_valid_o = state_r.flt_valid;
  assign flt_reason_o = state_r.flt_reason;
  assign flt_req_id_o = state_r.flt_req_id;
  assign flt_addr_o = state_r.flt_addr;
  assign irq_o = state_r.irq;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  property p_no_zero;
    @(posedge clk_sys_i) disable iff (rst_i)
      flt_valid_o |-> flt_reason_o != REASON_NONE;
  endproperty
  a_no_zero: assert property (p_no_zero) else $error("zero code");

  property p_root_np;
    @(posedge clk_sys_i) disable iff (rst_i)
      ce_i && chk_valid_i && !chk_root_fetch_err_i && !chk_extended_i &&
      !chk_root_present_i |=> flt_valid_o && flt_reason_o == 8'h01;
  endproperty
  a_root_np: assert property (p_root_np) else $error("no 1h");

  property p_root_err;
    @(posedge clk_sys_i) disable iff (rst_i)
      ce_i && chk_valid_i && chk_root_fetch_err_i |=> flt_reason_o == 8'h08;
  endproperty
  a_root_err: assert property (p_root_err) else $error("no 8h");

  property p_ctx_np;
    @(posedge clk_sys_i) disable iff (rst_i)
      ce_i && chk_valid_i && !chk_root_fetch_err_i && !chk_extended_i &&
      chk_root_present_i && !chk_root_rsvd_i && !chk_ctx_fetch_err_i &&
      !chk_ctx_present_i |=> flt_valid_o && flt_reason_o == 8'h02;
  endproperty
  a_ctx_np: assert property (p_ctx_np) else $error("no 2h");

  property p_zlr;
    @(posedge clk_sys_i) disable iff (rst_i)
      state_r.zlr_cap && chk_zero_len_i && chk_page_write_ok_i |->
      reason != REASON_NO_READ;
  endproperty
  a_zlr: assert property (p_zlr) else $error("zlr read fault");

  property p_wr_perm;
    @(posedge clk_sys_i) disable iff (rst_i)
      reason == REASON_NO_WRITE |-> chk_is_write_i && !chk_page_write_ok_i;
  endproperty
  a_wr_perm: assert property (p_wr_perm) else $error("bad 5h");

  property p_width;
    @(posedge clk_sys_i) disable iff (rst_i)
      reason == REASON_ADDR_TOO_WIDE |-> addr_over && chk_ctx_present_i;
  endproperty
  a_width: assert property (p_width) else $error("bad 4h");

  property p_report;
    @(posedge clk_sys_i) disable iff (rst_i)
      ce_i && chk_valid_i && reason != REASON_NONE |=>
      flt_valid_o && flt_req_id_o == $past(chk_req_id_i) &&
      flt_reason_o == $past(reason);
  endproperty
  a_report: assert property (p_report) else $error("no report");

endmodule : fault_reason_classifier

`default_nettype wire

// ### core/fault_reason_pkg.sv
package fault_reason_pkg;

  // ----------------------------------------------------------------------
  // fault reason encodings
  // ----------------------------------------------------------------------
  localparam int REASON_W = 8;
  localparam logic [7:0] REASON_NONE = 8'h00;
  localparam logic [7:0] REASON_ROOT_NOT_PRESENT = 8'h01;
  localparam logic [7:0] REASON_CTX_NOT_PRESENT = 8'h02;
  localparam logic [7:0] REASON_CTX_BAD_PROG = 8'h03;
  localparam logic [7:0] REASON_ADDR_TOO_WIDE = 8'h04;
  localparam logic [7:0] REASON_NO_WRITE = 8'h05;
  localparam logic [7:0] REASON_NO_READ = 8'h06;
  localparam logic [7:0] REASON_SS_FETCH_ERR = 8'h07;
  localparam logic [7:0] REASON_ROOT_FETCH_ERR = 8'h08;
  localparam logic [7:0] REASON_CTX_FETCH_ERR = 8'h09;
  localparam logic [7:0] REASON_ROOT_RSVD = 8'h0a;
  localparam logic [7:0] REASON_CTX_RSVD = 8'h0b;
  localparam logic [7:0] REASON_SS_RSVD = 8'h0c;

  // ----------------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------------
  localparam int ADDR_W = 64;
  localparam int WIDTH_W = 7;
  localparam int REQ_ID_W = 16;

  // ----------------------------------------------------------------------
  // apb register map
  // ----------------------------------------------------------------------
  localparam int APB_AW = 12;
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_STATUS = 12'h004;
  localparam logic [11:0] OFS_MASK = 12'h008;
  localparam logic [11:0] OFS_LAST = 12'h00c;
  localparam logic [11:0] OFS_COUNT = 12'h010;
  localparam int CTRL_ZLR_BIT = 0;
  localparam int CTRL_MAX_GUEST_WIDTH_LSB = 8;
  localparam logic [6:0] MAX_GUEST_WIDTH_RESET = 7'h30;
  localparam int STAT_FAULT_BIT = 0;
  localparam int STAT_OVF_BIT = 1;
  localparam int STAT_W = 2;
  localparam int COUNT_W = 16;

endpackage : fault_reason_pkg

// ### test/dma_remap_fault_reason_bench.sv
`timescale 1ns/1ps
`default_nettype none
module dma_remap_fault_reason_bench;
  import fault_reason_pkg::*;
  // ---------------------------------------------------------------
  // stimulus and observed signals
  // ---------------------------------------------------------------
  logic clk_sys_i = 0, rst_i = 1, ce_i = 1, go = 0;
  logic psel_i = 0, penable_i = 0, pwrite_i = 0;
  logic [11:0] paddr_i = 0;
  logic [31:0] pwdata_i = 0, prdata_o;
  logic [3:0] kind = 0;
  logic [15:0] id = 0, flt_req_id_o;
  logic [63:0] addr = 0, flt_addr_o;
  logic pready_o, pslverr_o, flt_valid_o, irq_o;
  logic [7:0] flt_reason_o;
  wire logic chk_valid_i, chk_is_write_i, chk_is_read_i, chk_zero_len_i;
  wire logic chk_extended_i, chk_root_fetch_err_i, chk_root_present_i;
  wire logic chk_root_rsvd_i, chk_ctx_fetch_err_i, chk_ctx_present_i;
  wire logic chk_ctx_rsvd_i, chk_ctx_bad_prog_i, chk_ss_fetch_err_i;
  wire logic chk_ss_rsvd_i, chk_ss_live_i, chk_page_read_ok_i;
  wire logic chk_page_write_ok_i;
  wire logic [1:0] chk_half_present_flags_i;
  wire logic [6:0] chk_context_width_setting_i;
  wire logic [15:0] chk_req_id_i;
  wire logic [63:0] chk_addr_i;
  int err_count = 0, check_count = 0, nflt = 0;
  integer seed = 32'h7b10b69a;
  logic [87:0] q[$];
  logic [87:0] last = 0;

  // 125 MHz system clock
  always #4 clk_sys_i = ~clk_sys_i;

  walk_result_model model (.clk_i(clk_sys_i), .go_i(go), .kind_i(kind),
    .id_i(id), .addr_i(addr), .chk_valid_i, .chk_req_id_i, .chk_addr_i,
    .chk_is_write_i, .chk_is_read_i, .chk_zero_len_i, .chk_extended_i,
    .chk_root_fetch_err_i, .chk_root_present_i, .chk_half_present_flags_i,
    .chk_root_rsvd_i, .chk_ctx_fetch_err_i, .chk_ctx_present_i,
    .chk_ctx_rsvd_i, .chk_ctx_bad_prog_i, .chk_context_width_setting_i,
    .chk_ss_fetch_err_i, .chk_ss_rsvd_i, .chk_ss_live_i,
    .chk_page_read_ok_i, .chk_page_write_ok_i);

  fault_reason_classifier dut (.clk_sys_i, .rst_i, .ce_i, .chk_valid_i,
    .chk_req_id_i, .chk_addr_i, .chk_is_write_i, .chk_is_read_i,
    .chk_zero_len_i, .chk_extended_i, .chk_root_fetch_err_i,
    .chk_root_present_i, .chk_half_present_flags_i, .chk_root_rsvd_i,
    .chk_ctx_fetch_err_i, .chk_ctx_present_i, .chk_ctx_rsvd_i,
    .chk_ctx_bad_prog_i, .chk_context_width_setting_i, .chk_ss_fetch_err_i,
    .chk_ss_rsvd_i, .chk_ss_live_i, .chk_page_read_ok_i,
    .chk_page_write_ok_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
    .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .flt_valid_o,
    .flt_reason_o, .flt_req_id_o, .flt_addr_o, .irq_o);

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task check(input string what, input logic [87:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task report_and_stop;
    $display("comparisons %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop

  // one apb transfer; request held until pready is seen at an edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, e,
           input logic eerr);
    int n;
    @(posedge clk_sys_i);
    {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} <= {2'b10, w, a, d};
    @(posedge clk_sys_i);
    penable_i <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (pready_o !== 1'b1 && n < 16);
    if (pready_o !== 1'b1) begin
      err_count++;
      report_and_stop;
    end
    check("pslverr", pslverr_o, eerr);
    if (!w) check("prdata", prdata_o, e);
    {psel_i, penable_i} <= 2'b00;
  endtask : apb

  // one walk per call; calls back to back give one walk every cycle
  task walk(input logic [3:0] k, input logic cap);
    logic [7:0] r;
    logic [15:0] i;
    logic [63:0] a;
    i = 16'($random(seed));
    a = {32'h0, 32'($random(seed))};
    case (k)
      4'h0, 4'hf: r = 8'h00;
      4'hd: r = cap ? 8'h00 : 8'h06;
      4'he: r = 8'h01;
      default: r = {4'h0, k};
    endcase
    if (k == 4'h4) a = 64'h0001_0000_0000_0000;
    if (r != 8'h00) begin
      q.push_back({i, a, r});
      last = {i, a, r};
      nflt++;
    end
    @(posedge clk_sys_i);
    {go, kind, id, addr} <= {1'b1, k, i, a};
  endtask : walk

  // scoreboard: each fault pulse takes the oldest expectation
  always @(posedge clk_sys_i) begin
    if (!rst_i && flt_valid_o === 1'b1) begin
      if (q.size() == 0) check("unexpected fault", 1'b1, 1'b0);
      else check("fault", {flt_req_id_o, flt_addr_o, flt_reason_o},
                 q.pop_front());
    end
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    apb(0, OFS_CTRL, 0, 32'h0000_3000, 0);
    apb(0, OFS_LAST, 0, 0, 0);
    apb(0, 12'h014, 0, 0, 1);
    apb(1, OFS_LAST, 32'hffff_ffff, 0, 1);
    $display("test registers done");
    for (int c = 0; c < 2; c++) begin
      for (int k = 0; k < 16; k++) walk(4'(k), c[0]);
      @(posedge clk_sys_i);
      go <= 1'b0;
      repeat (4) @(posedge clk_sys_i);
      check("pending faults", 88'(q.size()), 0);
      if (c == 0) apb(1, OFS_CTRL, 32'h0000_3001, 0, 0);
    end
    // a walk while the enable is low must leave no trace in the count
    @(posedge clk_sys_i);
    {ce_i, go, kind} <= {1'b0, 1'b1, 4'h1};
    @(posedge clk_sys_i);
    go <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    ce_i <= 1'b1;
    $display("test fault codes done");
    apb(0, OFS_COUNT, 0, 32'(nflt), 0);
    apb(0, OFS_STATUS, 0, 32'h3, 0);
    apb(0, OFS_LAST, 0, {last[87:72], 8'h00, last[7:0]}, 0);
    check("irq masked", irq_o, 1'b0);
    apb(1, OFS_MASK, 32'h1, 0, 0);
    repeat (2) @(posedge clk_sys_i);
    check("irq raised", irq_o, 1'b1);
    apb(1, OFS_STATUS, 32'h3, 0, 0);
    repeat (2) @(posedge clk_sys_i);
    check("irq cleared", irq_o, 1'b0);
    apb(1, OFS_COUNT, 0, 0, 0);
    apb(0, OFS_COUNT, 0, 0, 0);
    $display("test interrupt done");
    report_and_stop;
  end
endmodule : dma_remap_fault_reason_bench
`default_nettype wire

// ### test/walk_result_model.sv
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// walker result source: one finished walk per go, noise when idle
// ---------------------------------------------------------------
module walk_result_model (
  // control from the bench
  input wire logic clk_i,
  input wire logic go_i,
  input wire logic [3:0] kind_i,
  input wire logic [15:0] id_i,
  input wire logic [63:0] addr_i,
  // walk result, named as the classifier sees it
  output logic chk_valid_i,
  output logic [15:0] chk_req_id_i,
  output logic [63:0] chk_addr_i,
  output logic chk_is_write_i, chk_is_read_i, chk_zero_len_i, chk_extended_i,
  output logic chk_root_fetch_err_i, chk_root_present_i, chk_root_rsvd_i,
  output logic [1:0] chk_half_present_flags_i,
  output logic chk_ctx_fetch_err_i, chk_ctx_present_i, chk_ctx_rsvd_i,
  output logic chk_ctx_bad_prog_i,
  output logic [6:0] chk_context_width_setting_i,
  output logic chk_ss_fetch_err_i, chk_ss_rsvd_i, chk_ss_live_i,
  output logic chk_page_read_ok_i, chk_page_write_ok_i
);
  integer seed = 32'h7b10b69a;

  // idle cycles carry noise so that a stale field never looks like a walk
  always @(posedge clk_i) begin
    chk_valid_i <= go_i;
    {chk_req_id_i, chk_addr_i, chk_is_write_i, chk_is_read_i, chk_zero_len_i,
     chk_extended_i, chk_root_fetch_err_i, chk_root_present_i,
     chk_half_present_flags_i, chk_root_rsvd_i, chk_ctx_fetch_err_i,
     chk_ctx_present_i, chk_ctx_rsvd_i, chk_ctx_bad_prog_i,
     chk_context_width_setting_i, chk_ss_fetch_err_i, chk_ss_rsvd_i,
     chk_ss_live_i, chk_page_read_ok_i, chk_page_write_ok_i}
      <= 105'({$random(seed), $random(seed), $random(seed), $random(seed)});
    if (go_i) begin
      // healthy read walk, then one defect per kind
      {chk_req_id_i, chk_addr_i} <= {id_i, addr_i};
      {chk_is_write_i, chk_is_read_i, chk_zero_len_i, chk_extended_i} <= 4'h4;
      {chk_root_fetch_err_i, chk_root_present_i} <= 2'b01;
      {chk_half_present_flags_i, chk_root_rsvd_i} <= 3'b110;
      {chk_ctx_fetch_err_i, chk_ctx_present_i} <= 2'b01;
      {chk_ctx_rsvd_i, chk_ctx_bad_prog_i} <= 2'b00;
      chk_context_width_setting_i <= 7'h30;
      {chk_ss_fetch_err_i, chk_ss_rsvd_i, chk_ss_live_i} <= 3'b001;
      {chk_page_read_ok_i, chk_page_write_ok_i} <= 2'b11;
      case (kind_i)
        4'h1: chk_root_present_i <= 1'b0; // root absent
        4'h2: chk_ctx_present_i <= 1'b0; // context absent
        4'h3: chk_ctx_bad_prog_i <= 1'b1; // bad context
        4'h4: chk_addr_i <= 64'h0001_0000_0000_0000; // one past 48 bits
        4'h5: begin // write to read-only page
          {chk_is_write_i, chk_is_read_i, chk_page_write_ok_i} <= 3'b100;
        end
        4'h6: chk_page_read_ok_i <= 1'b0; // read to write-only
        4'h7: chk_ss_fetch_err_i <= 1'b1; // table fetch fails
        4'h8: chk_root_fetch_err_i <= 1'b1; // root fetch fails
        4'h9: chk_ctx_fetch_err_i <= 1'b1; // context fetch fails
        4'ha: chk_root_rsvd_i <= 1'b1; // root junk bits
        4'hb: chk_ctx_rsvd_i <= 1'b1; // context junk bits
        4'hc: chk_ss_rsvd_i <= 1'b1; // live entry junk bits
        4'hd: begin // zero length read, write-only page
          {chk_zero_len_i, chk_page_read_ok_i} <= 2'b10;
        end
        4'he: begin // extended, used half absent
          {chk_extended_i, chk_half_present_flags_i} <= 3'b110;
        end
        4'hf: begin // top legal address, dead entry junk
          chk_addr_i <= 64'h0000_ffff_ffff_ffff;
          {chk_ss_rsvd_i, chk_ss_live_i} <= 2'b10;
        end
        default: ;
      endcase
    end
  end
endmodule : walk_result_model
`default_nettype wire
